//--- asmon_top.v
// Signal monitor control and status block with its AXI4-Lite register slave
//
// Added by the designer: register access over AXI4-Lite.
`include "asmon_consts.vh"

module asmon_top (
	input  wire        clk,
	input  wire        arst_n,
	// AXI4-Lite write address channel
	input  wire [11:0] s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// AXI4-Lite write data channel
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// AXI4-Lite write response channel
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address channel
	input  wire [11:0] s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// AXI4-Lite read data channel
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Converter samples and system reference
	input  wire        sampleValid,
	input  wire [15:0] sampleData,
	input  wire        sysrefIn,
	input  wire        sysrefEnabled,
	// Result stream towards the serial framer, and the sync applied pulse
	output reg         framerValid,
	output reg  [19:0] framerData,
	output reg         syncApplied
);

	// Write channel holding registers
	reg         awHeld;
	reg  [9:0]  awIndex;
	reg         wHeld;
	reg  [7:0]  wByte;
	reg         wLane0;

	// Software visible state
	reg         syncMode;
	reg         peakEnable;
	reg  [2:0]  resultSelect;
	reg  [19:0] statusResult;
	reg         framerEnable;
	reg  [5:0]  framerSelect;
	wire [23:0] periodValue;

	// Internal strobes and values
	reg         sysrefPrev;
	wire        sysrefEdge;
	wire        syncNow;
	wire        doWrite;
	wire        wrEn;
	wire        updateNow;
	wire        periodDone;
	wire [19:0] peakResult;
	wire [7:0]  frameCount;
	wire [9:0]  arIndex;

	// Word index of a byte address
	function [9:0] regIndex;
		input [11:0] addr;
		begin
			regIndex = addr[11:2];
		end
	endfunction

	// Whether an index names one of the registers
	function isMapped;
		input [9:0] idx;
		begin
			isMapped = (idx >= `ASMON_IDX_SYNC) && (idx <= `ASMON_IDX_FSEL);
		end
	endfunction

	// Byte value of a register as software reads it
	function [7:0] readByte;
		input [9:0] idx;
		begin
			case (idx)
				`ASMON_IDX_SYNC:     readByte = {7'h00, syncMode};
				`ASMON_IDX_CTRL:     readByte = {6'h00, peakEnable, 1'b0};
				`ASMON_IDX_PERIOD0:  readByte = periodValue[7:0];
				`ASMON_IDX_PERIOD1:  readByte = periodValue[15:8];
				`ASMON_IDX_PERIOD2:  readByte = periodValue[23:16];
				`ASMON_IDX_STATCTRL: readByte = {5'h00, resultSelect};
				`ASMON_IDX_RES0:     readByte = statusResult[7:0];
				`ASMON_IDX_RES1:     readByte = statusResult[15:8];
				`ASMON_IDX_RES2:     readByte = {4'h0, statusResult[19:16]};
				`ASMON_IDX_FRAME:    readByte = frameCount;
				`ASMON_IDX_FRAMER:   readByte = {7'h00, framerEnable};
				`ASMON_IDX_FSEL:     readByte = {2'h0, framerSelect};
				default:             readByte = 8'h00;
			endcase
		end
	endfunction

	// Channel readiness: one outstanding item per channel
	assign s_axi_awready = !awHeld;
	assign s_axi_wready  = !wHeld;
	assign s_axi_arready = !s_axi_rvalid;
	assign arIndex       = regIndex(s_axi_araddr);

	// A write completes once address and data are both held and no response waits
	assign doWrite = awHeld && wHeld && !s_axi_bvalid;
	assign wrEn    = doWrite && wLane0 && isMapped(awIndex);

	// Write address capture
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			awHeld  <= 1'b0;
			awIndex <= 10'h000;
		end else if (s_axi_awvalid && !awHeld) begin
			awHeld  <= 1'b1;
			awIndex <= regIndex(s_axi_awaddr);
		end else if (doWrite) begin
			awHeld  <= 1'b0;
		end
	end

	// Write data capture; only the low byte lane carries register bits
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wHeld  <= 1'b0;
			wByte  <= 8'h00;
			wLane0 <= 1'b0;
		end else if (s_axi_wvalid && !wHeld) begin
			wHeld  <= 1'b1;
			wByte  <= s_axi_wdata[7:0];
			wLane0 <= s_axi_wstrb[0];
		end else if (doWrite) begin
			wHeld  <= 1'b0;
		end
	end

	// Write response; unmapped addresses answer with a slave error
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `ASMON_RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= isMapped(awIndex) ? `ASMON_RESP_OKAY : `ASMON_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read response, one cycle after the address is taken
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `ASMON_RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h000000, readByte(arIndex)};
			s_axi_rresp  <= isMapped(arIndex) ? `ASMON_RESP_OKAY : `ASMON_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Rising edge of the reference, counted only while the input is enabled
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sysrefPrev <= 1'b0;
		end else begin
			sysrefPrev <= sysrefIn;
		end
	end

	assign sysrefEdge = sysrefIn && !sysrefPrev && sysrefEnabled;
	assign syncNow    = syncMode && sysrefEdge;

	// One-shot sync mode; a software write in the same cycle overrides the clear
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			syncMode <= `ASMON_RST_SYNCMODE;
		end else if (wrEn && (awIndex == `ASMON_IDX_SYNC)) begin
			syncMode <= wByte[`ASMON_BIT_SYNCMODE];
		end else if (syncNow) begin
			syncMode <= 1'b0;
		end
	end

	// Registered pulse showing that a sync restarted the monitor
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			syncApplied <= 1'b0;
		end else begin
			syncApplied <= syncNow;
		end
	end

	// Peak detector enable
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			peakEnable <= `ASMON_RST_PEAKEN;
		end else if (wrEn && (awIndex == `ASMON_IDX_CTRL)) begin
			peakEnable <= wByte[`ASMON_BIT_PEAKEN];
		end
	end

	// Three period bytes, one register each
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : periodGen
			localparam integer IDXI = `ASMON_IDX_PERIOD0 + i;
			localparam [9:0]   IDX  = IDXI[9:0];
			localparam [7:0] RST = (i == 0) ? `ASMON_RST_PERIOD0 : `ASMON_RST_PERIODHI;
			reg [7:0] byteReg;
			always @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					byteReg <= RST;
				end else if (wrEn && (awIndex == IDX)) begin
					byteReg <= wByte;
				end
			end
			assign periodValue[8*i+7:8*i] = byteReg;
		end
	endgenerate

	// Result selection; the update bit is a strobe and never stored
	assign updateNow = wrEn && (awIndex == `ASMON_IDX_STATCTRL) && wByte[`ASMON_BIT_UPDATE];

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			resultSelect <= `ASMON_RST_SELECT;
		end else if (wrEn && (awIndex == `ASMON_IDX_STATCTRL)) begin
			resultSelect <= wByte[`ASMON_SEL_HI:`ASMON_SEL_LO];
		end
	end

	// Readback refresh; the selection written with the update takes effect at once
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			statusResult <= `ASMON_RST_RESULT;
		end else if (updateNow) begin
			if (wByte[`ASMON_SEL_HI:`ASMON_SEL_LO] == `ASMON_SEL_PEAK) begin
				statusResult <= peakResult;
			end else begin
				statusResult <= `ASMON_RST_RESULT;
			end
		end
	end

	// Framer insertion enable and input selection
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			framerEnable <= `ASMON_RST_FRAMEREN;
			framerSelect <= `ASMON_RST_FSEL;
		end else if (wrEn && (awIndex == `ASMON_IDX_FRAMER)) begin
			framerEnable <= wByte[`ASMON_BIT_FRAMEREN];
		end else if (wrEn && (awIndex == `ASMON_IDX_FSEL)) begin
			framerSelect <= wByte[`ASMON_FSEL_HI:0];
		end
	end

	// Each finished period's peak goes to the framer while the framer enable and the peak select bit stand
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			framerValid <= 1'b0;
			framerData  <= `ASMON_RST_RESULT;
		end else if (periodDone && framerEnable && framerSelect[`ASMON_BIT_FSEL_PEAK]) begin
			framerValid <= 1'b1;
			framerData  <= peakResult;
		end else begin
			framerValid <= 1'b0;
		end
	end

	// Measurement engine, restarted by an accepted sync
	asmon_peak peakUnit (
		.clk          (clk),
		.arst_n       (arst_n),
		.peakEnable   (peakEnable),
		.periodLength (periodValue),
		.restart      (syncNow),
		.sampleValid  (sampleValid),
		.sampleData   (sampleData),
		.periodDone   (periodDone),
		.peakResult   (peakResult),
		.frameCount   (frameCount)
	);

endmodule // asmon_top

//--- asmon_consts.vh
// Register indices, field positions, reset values and bus codes of the signal monitor
`ifndef ASMON_CONSTS_VH
`define ASMON_CONSTS_VH

// Register indices; the byte address is four times the index
`define ASMON_IDX_SYNC      10'h26f
`define ASMON_IDX_CTRL      10'h270
`define ASMON_IDX_PERIOD0   10'h271
`define ASMON_IDX_PERIOD1   10'h272
`define ASMON_IDX_PERIOD2   10'h273
`define ASMON_IDX_STATCTRL  10'h274
`define ASMON_IDX_RES0      10'h275
`define ASMON_IDX_RES1      10'h276
`define ASMON_IDX_RES2      10'h277
`define ASMON_IDX_FRAME     10'h278
`define ASMON_IDX_FRAMER    10'h279
`define ASMON_IDX_FSEL      10'h27a

// Reset values
`define ASMON_RST_SYNCMODE  1'b0
`define ASMON_RST_PEAKEN    1'b0
`define ASMON_RST_PERIOD0   8'h80
`define ASMON_RST_PERIODHI  8'h00
`define ASMON_RST_SELECT    3'h1
`define ASMON_RST_FRAMEREN  1'b0
`define ASMON_RST_FSEL      6'h02
`define ASMON_RST_RESULT    20'h00000
`define ASMON_RST_FRAME     8'h00

// Field positions
`define ASMON_BIT_SYNCMODE  0
`define ASMON_BIT_PEAKEN    1
`define ASMON_BIT_UPDATE    4
`define ASMON_SEL_HI        2
`define ASMON_SEL_LO        0
`define ASMON_BIT_FRAMEREN  0
`define ASMON_FSEL_HI       5
`define ASMON_BIT_FSEL_PEAK 1

// Encodings and limits
`define ASMON_SEL_PEAK      3'h1
`define ASMON_PERIOD_MIN    24'h000002
`define ASMON_RESP_OKAY     2'h0
`define ASMON_RESP_SLVERR   2'h2

`endif

//--- asmon_peak.v
// Peak detector, measurement period counter and frame counter of the signal monitor
`include "asmon_consts.vh"

module asmon_peak (
	input  wire        clk,
	input  wire        arst_n,
	input  wire        peakEnable,
	input  wire [23:0] periodLength,
	input  wire        restart,
	input  wire        sampleValid,
	input  wire [15:0] sampleData,
	output reg         periodDone,
	output reg  [19:0] peakResult,
	output reg  [7:0]  frameCount
);

	reg  [23:0] cycleCount;
	reg  [15:0] peakHold;
	wire [23:0] evenLength;
	wire [23:0] limit;
	wire [15:0] magnitude;
	wire        newPeak;
	wire [15:0] finalPeak;

	// Bit 0 of the period is dropped; a too short period is raised to the minimum
	assign evenLength = {periodLength[23:1], 1'b0};
	assign limit      = (evenLength < `ASMON_PERIOD_MIN) ? `ASMON_PERIOD_MIN : evenLength;

	// Magnitude of a two's complement sample; full negative scale maps to 0x8000
	assign magnitude = sampleData[15] ? (~sampleData + 16'h0001) : sampleData;
	assign newPeak   = peakEnable && sampleValid && (magnitude > peakHold);
	assign finalPeak = newPeak ? magnitude : peakHold;

	// Period counter, peak hold and frame counter
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cycleCount <= 24'h000000;
			peakHold   <= 16'h0000;
			periodDone <= 1'b0;
			peakResult <= `ASMON_RST_RESULT;
			frameCount <= `ASMON_RST_FRAME;
		end else if (restart) begin
			cycleCount <= 24'h000000;
			peakHold   <= 16'h0000;
			periodDone <= 1'b0;
		end else if (cycleCount >= limit - 24'h000001) begin
			cycleCount <= 24'h000000;
			peakHold   <= 16'h0000;
			periodDone <= 1'b1;
			peakResult <= peakEnable ? {4'h0, finalPeak} : 20'h00000;
			frameCount <= frameCount + 8'h01;
		end else begin
			cycleCount <= cycleCount + 24'h000001;
			peakHold   <= finalPeak;
			periodDone <= 1'b0;
		end
	end

endmodule // asmon_peak

//--- asmon_top_sva.sv
// Checker for the signal monitor bus and result ports
`include "asmon_consts.vh"
module asmon_checker (
	input wire        clk,
	input wire        arst_n,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        sysrefIn,
	input wire        sysrefEnabled,
	input wire        framerValid,
	input wire        syncApplied
);
	// Read request taken and its register index
	wire       arOk  = s_axi_arvalid && s_axi_arready;
	wire [9:0] arIdx = s_axi_araddr[11:2];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// Read data one edge after the address is taken; write response two edges after address and data are taken together
	property p_rd_lat; arOk |=> s_axi_rvalid; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
			|-> ##2 s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
	// Answers stand until taken
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	// Byte registers read with zero upper bits; unmapped reads are refused
	property p_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_unmap;
		arOk && (arIdx < `ASMON_IDX_SYNC || arIdx > `ASMON_IDX_FSEL)
			|=> s_axi_rresp == `ASMON_RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
	// Sync pulse only after an enabled rising reference edge
	property p_sync_cause;
		syncApplied |-> $past(sysrefIn) && !$past(sysrefIn, 2) && $past(sysrefEnabled);
	endproperty
	a_sync_cause: assert property (p_sync_cause) else $error("sync without edge");
	// Period is at least two cycles, so framer pulses never touch
	property p_frm_gap; framerValid |=> !framerValid; endproperty
	a_frm_gap: assert property (p_frm_gap) else $error("framer pulses adjacent");
	c_frame: cover property (framerValid);
	c_sync: cover property (syncApplied);
	c_unmap: cover property (arOk && arIdx > `ASMON_IDX_FSEL);
endmodule // asmon_checker

bind asmon_top asmon_checker i_chk (
	.clk, .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.sysrefIn, .sysrefEnabled, .framerValid, .syncApplied
);

//--- asmon_bench.sv
// Self-checking bench for the signal monitor registers and results
`include "asmon_consts.vh"
module asmon_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        arst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sampleValid = 1'b0;
	logic        sysrefIn = 1'b0, sysrefEnabled = 1'b0, s_axi_rvalid, framerValid, syncApplied;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [15:0] sampleData = 16'h0;
	logic [19:0] framerData;
	logic [7:0]  f0;
	logic [7:0]  rst [12] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h1, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h2};
	int          n_fail, checked, nPulse, nSync, p, i;

	asmon_top i_dut (
		.clk, .arst_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sampleValid,
		.sampleData, .sysrefIn, .sysrefEnabled, .framerValid, .framerData, .syncApplied
	);

	// Clock and pulse counters
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		if (framerValid === 1'b1) nPulse <= nPulse + 1;
		if (syncApplied === 1'b1) nSync <= nSync + 1;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic hang;
		n_fail++;
		$display("wait bound used up");
		complete_run();
	endtask
	// Write one register, releasing each channel at the edge that takes it
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		int n;
		logic a, w, b;
		@(posedge clk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(negedge clk);
			a = s_axi_awready;
			w = s_axi_wready;
			b = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge clk);
			if (a === 1'b1) s_axi_awvalid <= 1'b0;
			if (w === 1'b1) s_axi_wvalid <= 1'b0;
			if (b === 1'b1) break;
		end
		s_axi_bready <= 1'b0;
		if (n == 40) hang();
		chk(rsp, (idx < `ASMON_IDX_SYNC || idx > `ASMON_IDX_FSEL) ? 2'h2 : 2'h0);
	endtask
	// Read one register
	task automatic rd(input logic [9:0] idx, output logic [31:0] d);
		int n;
		logic a, r;
		@(posedge clk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(negedge clk);
			a = s_axi_arready;
			r = s_axi_rvalid;
			d = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge clk);
			if (a === 1'b1) s_axi_arvalid <= 1'b0;
			if (r === 1'b1) break;
		end
		s_axi_rready <= 1'b0;
		if (n == 40) hang();
	endtask
	task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
		rd(idx, v);
		chk(v, {24'h0, exp});
	endtask
	// Count framer pulses over a fixed span
	task automatic pulses(input int len, input int exp);
		@(posedge clk); // Lets a pulse sent under the old settings be counted first
		p = nPulse;
		repeat (len) @(posedge clk);
		chk(nPulse - p, exp);
	endtask
	task automatic sref;
		@(posedge clk);
		sysrefIn <= 1'b1;
		repeat (3) @(posedge clk);
		sysrefIn <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		rdc(`ASMON_IDX_PERIOD0, 8'h80);
		wr(`ASMON_IDX_PERIOD0, 8'h11);
		for (i = 0; i < 12; i++) begin
			if (i != 2 && i != 9) rdc(10'(`ASMON_IDX_SYNC + i), rst[i]);
		end
		$display("reset values done");
		rd(10'h300, v);
		chk(rsp, `ASMON_RESP_SLVERR);
		wr(10'h300, 8'hff);
		wr(`ASMON_IDX_CTRL, 8'hff);
		rdc(`ASMON_IDX_CTRL, 8'h02);
		wr(`ASMON_IDX_RES0, 8'hff);
		rdc(`ASMON_IDX_RES0, 8'h00);
		wr(`ASMON_IDX_FSEL, 8'hff);
		rdc(`ASMON_IDX_FSEL, 8'h3f);
		wr(`ASMON_IDX_STATCTRL, 8'hff);
		rdc(`ASMON_IDX_STATCTRL, 8'h07);
		wr(`ASMON_IDX_PERIOD2, 8'h5a);
		rdc(`ASMON_IDX_PERIOD2, 8'h5a);
		wr(`ASMON_IDX_PERIOD2, 8'h00);
		wr(`ASMON_IDX_FSEL, 8'h02);
		wr(`ASMON_IDX_FRAMER, 8'h01);
		$display("register access done");
		rd(`ASMON_IDX_FRAME, v);
		f0 = v[7:0];
		pulses(640, 40);
		rd(`ASMON_IDX_FRAME, v);
		chk(8'(v[7:0] - f0 - 8'd40) < 8'd2, 1'b1);
		wr(`ASMON_IDX_FRAMER, 8'h00);
		pulses(64, 0);
		wr(`ASMON_IDX_FRAMER, 8'h01);
		wr(`ASMON_IDX_FSEL, 8'h00);
		pulses(64, 0);
		wr(`ASMON_IDX_FSEL, 8'h02);
		$display("period and framer done");
		sampleData <= 16'hedcc;
		sampleValid <= 1'b1;
		pulses(48, 3);
		chk(framerData, 20'h01234);
		wr(`ASMON_IDX_STATCTRL, 8'h11);
		rdc(`ASMON_IDX_RES0, 8'h34);
		rdc(`ASMON_IDX_RES1, 8'h12);
		rdc(`ASMON_IDX_RES2, 8'h00);
		sampleData <= 16'h8000;
		pulses(48, 3);
		rdc(`ASMON_IDX_RES1, 8'h12);
		wr(`ASMON_IDX_STATCTRL, 8'h11);
		rdc(`ASMON_IDX_RES1, 8'h80);
		wr(`ASMON_IDX_STATCTRL, 8'h12);
		rdc(`ASMON_IDX_RES1, 8'h00);
		rdc(`ASMON_IDX_STATCTRL, 8'h02);
		wr(`ASMON_IDX_CTRL, 8'h00);
		pulses(48, 3);
		wr(`ASMON_IDX_STATCTRL, 8'h11);
		rdc(`ASMON_IDX_RES1, 8'h00);
		$display("peak results done");
		wr(`ASMON_IDX_SYNC, 8'h01);
		p = nSync;
		sref();
		chk(nSync - p, 0);
		rdc(`ASMON_IDX_SYNC, 8'h01);
		sysrefEnabled <= 1'b1;
		sref();
		chk(nSync - p, 1);
		rdc(`ASMON_IDX_SYNC, 8'h00);
		sref();
		chk(nSync - p, 1);
		$display("sync done");
		complete_run();
	end
endmodule // asmon_bench
